// file: logic/tc16_pkg.sv
// Purpose: shared constants for the 16-bit three-mode timer/counter
// Assumes: mclk is the high-frequency clock itself
// Notes:   register word offsets, field positions, reset values, taps

package tc16_pkg;

    // ------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam int          ADDR_W             = 4;
    localparam int          DATA_W             = 16;
    localparam logic [3:0]  ADDR_CONTROL       = 4'h0;
    localparam logic [3:0]  ADDR_MATCH         = 4'h1;
    localparam logic [3:0]  ADDR_MATCH_HIGH    = 4'h2;
    localparam logic [3:0]  ADDR_COUNT         = 4'h3;
    localparam logic [3:0]  ADDR_STATUS        = 4'h4;
    localparam logic [3:0]  ADDR_MASK          = 4'h5;
    localparam logic [3:0]  ADDR_SYS_CONFIG    = 4'h6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          CTL_WINDOW_BIT     = 0;
    localparam int          CTL_SELECT_LSB     = 2;
    localparam int          CTL_SELECT_MSB     = 4;
    localparam int          CTL_RUN_BIT        = 5;
    localparam int          CTL_W              = 6;
    localparam int          SYS_LOW_SPEED_BIT  = 0;
    localparam int          SYS_DIV_STAGE_BIT  = 1;
    localparam int          STAT_MATCH_BIT     = 0;
    localparam int          MATCH_MASKED_LSBS  = 11;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  CONTROL_RESET      = 6'h00;
    localparam logic [1:0]  SYS_CONFIG_RESET   = 2'h0;
    localparam logic        STATUS_RESET       = 1'b0;
    localparam logic        MASK_RESET         = 1'b0;

    // ------------------------------------------------------------
    // source clock select codes
    // ------------------------------------------------------------
    localparam logic [2:0]  SEL_SLOWEST        = 3'h0;
    localparam logic [2:0]  SEL_SLOW           = 3'h1;
    localparam logic [2:0]  SEL_MID            = 3'h2;
    localparam logic [2:0]  SEL_FAST           = 3'h3;
    localparam logic [2:0]  SEL_UNDIVIDED      = 3'h4;
    localparam logic [2:0]  SEL_LOW_FREQ       = 3'h5;
    localparam logic [2:0]  SEL_EXTERNAL       = 3'h7;

    // ------------------------------------------------------------
    // divider exponents (period = 2**n source periods)
    // ------------------------------------------------------------
    localparam int          FC_EXP_SLOWEST     = 23;
    localparam int          FC_EXP_SLOW        = 13;
    localparam int          FC_EXP_MID         = 8;
    localparam int          FC_EXP_FAST        = 3;
    localparam int          FS_EXP_SLOWEST     = 15;
    localparam int          FS_EXP_SLOW        = 5;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_EVENT,
        MODE_WINDOW
    } count_mode_t;

endpackage : tc16_pkg

// file: logic/source_tick_gen.sv
// Purpose: internal source clock prescaler, one tick per source period
// Assumes: fs_tick is a one-cycle pulse per low-frequency clock period
// Notes:   dividers free-run so a restart does not reset the phase
`timescale 1ns/100ps

module source_tick_gen
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        fs_tick,
    input  wire logic [2:0]  clock_select,
    input  wire logic        divider_stage_select,
    input  wire logic        low_speed_mode,
    output logic             src_tick
);

    logic [22:0] fc_div_r;
    logic [14:0] fs_div_r;
    logic        fc_tick_slowest;
    logic        fc_tick_slow;
    logic        fc_tick_mid;
    logic        fc_tick_fast;
    logic        fs_tick_slowest;
    logic        fs_tick_slow;
    logic        use_fs;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic low_ones(input logic [22:0] v, input int n);
        logic [22:0] m;
        m = 23'((64'h1 << n) - 64'h1);
        low_ones = ((v & m) == m);
    endfunction : low_ones

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fc_div_r <= 23'h000000;
            fs_div_r <= 15'h0000;
        end
        else
        begin
            fc_div_r <= fc_div_r + 23'h000001;
            if (fs_tick)
                fs_div_r <= fs_div_r + 15'h0001;
        end
    end

    assign fc_tick_slowest = low_ones(fc_div_r, tc16_pkg::FC_EXP_SLOWEST);
    assign fc_tick_slow    = low_ones(fc_div_r, tc16_pkg::FC_EXP_SLOW);
    assign fc_tick_mid     = low_ones(fc_div_r, tc16_pkg::FC_EXP_MID);
    assign fc_tick_fast    = low_ones(fc_div_r, tc16_pkg::FC_EXP_FAST);
    assign fs_tick_slowest = fs_tick &
        low_ones({8'h00, fs_div_r}, tc16_pkg::FS_EXP_SLOWEST);
    assign fs_tick_slow    = fs_tick &
        low_ones({8'h00, fs_div_r}, tc16_pkg::FS_EXP_SLOW);
    // in low-speed mode the divider chain runs from the slow clock
    assign use_fs = divider_stage_select | low_speed_mode;

    // ------------------------------------------------------------
    // source select
    // ------------------------------------------------------------
    always_comb
    begin
        case (clock_select)
            tc16_pkg::SEL_SLOWEST:
                src_tick = use_fs ? fs_tick_slowest : fc_tick_slowest;
            tc16_pkg::SEL_SLOW:
                src_tick = use_fs ? fs_tick_slow : fc_tick_slow;
            tc16_pkg::SEL_MID:
                src_tick = !low_speed_mode & fc_tick_mid;
            tc16_pkg::SEL_FAST:
                src_tick = !low_speed_mode & fc_tick_fast;
            tc16_pkg::SEL_UNDIVIDED:
                src_tick = low_speed_mode;
            tc16_pkg::SEL_LOW_FREQ:
                src_tick = !low_speed_mode & fs_tick;
            default:
                src_tick = 1'b0;
        endcase
    end

endmodule : source_tick_gen

// file: logic/timer_counter_16.sv
// Purpose: 16-bit up counter with timer, event and window modes
// Assumes: mclk is the high-frequency clock; pins are asynchronous
// Notes:   the match register has no reset; write it before starting
`timescale 1ns/100ps

module timer_counter_16
#(
    parameter int CNT_W = 16
)
(
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic [tc16_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [tc16_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [tc16_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                          count_input_pin,
    input  wire logic                          low_frequency_clock,
    output logic                               timer_match_interrupt
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (CNT_W != tc16_pkg::DATA_W)
    begin : g_bad_width
        $error("CNT_W must equal the register data width");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [tc16_pkg::CTL_W-1:0]   control_r;
    logic [CNT_W-1:0]             match_r;
    logic [1:0]                   sys_config_r;
    logic                         status_r;
    logic                         status_nxt;
    logic                         mask_r;
    logic [CNT_W-1:0]             count_r;
    logic [CNT_W-1:0]             count_nxt;
    logic [tc16_pkg::DATA_W-1:0]  rdata_r;
    logic [tc16_pkg::DATA_W-1:0]  rdata_nxt;
    logic                         cin_s1_r;
    logic                         cin_s2_r;
    logic                         cin_s3_r;
    logic                         fs_s1_r;
    logic                         fs_s2_r;
    logic                         fs_s3_r;
    logic                         cin_rise;
    logic                         cin_fall;
    logic                         fs_tick;
    logic                         src_tick;
    logic                         run_control_bit;
    logic                         window_mode_bit;
    logic [2:0]                   source_clock_select;
    logic                         low_speed_mode;
    logic                         divider_stage_select;
    logic                         upper_only;
    logic                         match_event;
    logic                         count_up;
    logic                         match_check;
    logic [CNT_W-1:0]             count_inc;
    logic [CNT_W-1:0]             compare_val;
    logic                         wr_control;
    logic                         wr_match;
    logic                         wr_match_high;
    logic                         wr_mask;
    logic                         wr_sys;
    logic                         rd_status;
    tc16_pkg::count_mode_t        mode;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // compare full word, or only the bits above the masked field
    function automatic logic word_match(
        input logic [CNT_W-1:0] a,
        input logic [CNT_W-1:0] b,
        input logic             upper
    );
        logic [CNT_W-1:0] m;
        m = upper ? ~CNT_W'((1 << tc16_pkg::MATCH_MASKED_LSBS) - 1)
                  : {CNT_W{1'b1}};
        word_match = ((a & m) == (b & m));
    endfunction : word_match

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cin_s1_r <= 1'b0;
            cin_s2_r <= 1'b0;
            cin_s3_r <= 1'b0;
            fs_s1_r  <= 1'b0;
            fs_s2_r  <= 1'b0;
            fs_s3_r  <= 1'b0;
        end
        else
        begin
            cin_s1_r <= count_input_pin;
            cin_s2_r <= cin_s1_r;
            cin_s3_r <= cin_s2_r;
            fs_s1_r  <= low_frequency_clock;
            fs_s2_r  <= fs_s1_r;
            fs_s3_r  <= fs_s2_r;
        end
    end

    // narrower pulses may be missed
    // edges come from flops two and three, never from the raw pin
    assign cin_rise = cin_s2_r & ~cin_s3_r;
    assign cin_fall = ~cin_s2_r & cin_s3_r;
    assign fs_tick  = fs_s2_r & ~fs_s3_r;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    // control bit layout
    assign run_control_bit      = control_r[tc16_pkg::CTL_RUN_BIT];
    assign window_mode_bit      = control_r[tc16_pkg::CTL_WINDOW_BIT];
    assign source_clock_select  =
        control_r[tc16_pkg::CTL_SELECT_MSB:tc16_pkg::CTL_SELECT_LSB];
    assign low_speed_mode       = sys_config_r[tc16_pkg::SYS_LOW_SPEED_BIT];
    assign divider_stage_select = sys_config_r[tc16_pkg::SYS_DIV_STAGE_BIT];

    // event mode is code 111 with window bit clear
    assign mode = window_mode_bit ? tc16_pkg::MODE_WINDOW :
                  (source_clock_select == tc16_pkg::SEL_EXTERNAL)
                      ? tc16_pkg::MODE_EVENT : tc16_pkg::MODE_TIMER;

    // only upper 5 bits with undivided fc in low speed
    assign upper_only = low_speed_mode &&
        (source_clock_select == tc16_pkg::SEL_UNDIVIDED);

    // ------------------------------------------------------------
    // source clock prescaler
    // ------------------------------------------------------------
    // source ticks
    source_tick_gen u_src
    (
        .mclk                 (mclk),
        .resetn               (resetn),
        .fs_tick              (fs_tick),
        .clock_select         (source_clock_select),
        .divider_stage_select (divider_stage_select),
        .low_speed_mode       (low_speed_mode),
        .src_tick             (src_tick)
    );

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    // timer compares the next value, so a match of n spans n ticks
    // and a match of zero spans a full wrap
    assign count_inc = count_r + CNT_W'(1);

    always_comb
    begin
        count_up    = 1'b0;
        match_check = 1'b0;
        compare_val = count_inc;
        case (mode)
            // count internal source, compare new value
            tc16_pkg::MODE_TIMER:
            begin
                count_up    = src_tick;
                match_check = src_tick;
            end
            // count rising edges of the pin
            tc16_pkg::MODE_EVENT:
            begin
                count_up    = cin_rise;
                match_check = cin_fall;
                compare_val = count_r;
            end
            tc16_pkg::MODE_WINDOW:
            begin
                count_up    = src_tick & cin_s2_r;
                match_check = src_tick & cin_s2_r;
            end
            default:
            begin
                count_up    = 1'b0;
                match_check = 1'b0;
            end
        endcase
    end

    assign match_event = run_control_bit & match_check &
        word_match(compare_val, match_r, upper_only);

    always_comb
    begin
        count_nxt = count_r;
        if (!run_control_bit)
            count_nxt = '0;
        // clear on match, then carry on
        else if (match_event)
            count_nxt = '0;
        else if (count_up)
            count_nxt = count_inc;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    assign wr_control    = reg_wr && (reg_addr == tc16_pkg::ADDR_CONTROL);
    assign wr_match      = reg_wr && (reg_addr == tc16_pkg::ADDR_MATCH);
    assign wr_match_high = reg_wr && (reg_addr == tc16_pkg::ADDR_MATCH_HIGH);
    assign wr_mask       = reg_wr && (reg_addr == tc16_pkg::ADDR_MASK);
    assign wr_sys        = reg_wr && (reg_addr == tc16_pkg::ADDR_SYS_CONFIG);
    assign rd_status     = reg_rd && (reg_addr == tc16_pkg::ADDR_STATUS);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            control_r    <= tc16_pkg::CONTROL_RESET;
            sys_config_r <= tc16_pkg::SYS_CONFIG_RESET;
            mask_r       <= tc16_pkg::MASK_RESET;
        end
        else
        begin
            if (wr_control)
                control_r <= reg_wdata[tc16_pkg::CTL_W-1:0];
            if (wr_sys)
                sys_config_r <= reg_wdata[1:0];
            if (wr_mask)
                mask_r <= reg_wdata[tc16_pkg::STAT_MATCH_BIT];
        end
    end

    // no reset on the match register
    // power-up value is unknown until software writes it
    always_ff @(posedge mclk)
    begin
        if (wr_match)
            match_r <= reg_wdata;
        else if (wr_match_high)
            match_r[CNT_W-1:CNT_W-8] <= reg_wdata[7:0];
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // a match in the clearing read cycle survives the clear
    assign status_nxt = match_event | (status_r & ~rd_status);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            status_r <= tc16_pkg::STATUS_RESET;
        else
            status_r <= status_nxt;
    end

    // interrupt raised from sticky match bit
    assign timer_match_interrupt = status_r & mask_r;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // idle cycles read zero so a stale word never lingers
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                tc16_pkg::ADDR_CONTROL:
                    rdata_nxt = {10'h000, control_r};
                tc16_pkg::ADDR_MATCH:
                    rdata_nxt = match_r;
                tc16_pkg::ADDR_MATCH_HIGH:
                    rdata_nxt = {8'h00, match_r[CNT_W-1:CNT_W-8]};
                tc16_pkg::ADDR_COUNT:
                    rdata_nxt = count_r;
                tc16_pkg::ADDR_STATUS:
                    rdata_nxt = {15'h0000, status_r};
                tc16_pkg::ADDR_MASK:
                    rdata_nxt = {15'h0000, mask_r};
                tc16_pkg::ADDR_SYS_CONFIG:
                    rdata_nxt = {14'h0000, sys_config_r};
                default:
                    rdata_nxt = '0;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // left to the pulse source and software

endmodule : timer_counter_16

// file: sim/tc16_asserts.sv
// Purpose: port-level checks for the three-mode timer/counter
// Assumes: bus tasks leave one idle cycle between strobes
// Notes:   status is hidden, so irq stands in for it
`timescale 1ns/100ps

module tc16_asserts
#(
    parameter int CNT_W = 16
)
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        count_input_pin,
    input wire logic        low_frequency_clock,
    input wire logic        timer_match_interrupt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence wr_rd(logic [3:0] a);
        reg_wr && reg_addr == a ##2 reg_rd && reg_addr == a;
    endsequence

    sequence hi_then_rd;
        reg_wr && reg_addr == tc16_pkg::ADDR_MATCH_HIGH
        ##2 reg_rd && reg_addr == tc16_pkg::ADDR_MATCH;
    endsequence

    sequence stop_then_rd;
        reg_wr && reg_addr == tc16_pkg::ADDR_CONTROL && !reg_wdata[5]
        ##2 reg_rd && reg_addr == tc16_pkg::ADDR_COUNT;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rd_idle_a: assert property (!$past(reg_rd)
        |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    match_width_a: assert property (wr_rd(tc16_pkg::ADDR_MATCH)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("match readback differs");
    high_byte_a: assert property (hi_then_rd
        |=> reg_rdata[15:8] == $past(reg_wdata[7:0], 3))
        else $error("high byte write lost");
    ctl_readback_a: assert property (wr_rd(tc16_pkg::ADDR_CONTROL)
        |=> reg_rdata == {10'h000, $past(reg_wdata[5:0], 3)})
        else $error("control readback differs");
    mask_readback_a: assert property (wr_rd(tc16_pkg::ADDR_MASK)
        |=> reg_rdata == {15'h0000, $past(reg_wdata[0], 3)})
        else $error("mask readback differs");
    stop_clear_a: assert property (stop_then_rd
        |=> reg_rdata == 16'h0000)
        else $error("stopped counter not zero");
    irq_sticky_a: assert property (timer_match_interrupt
        && !(reg_rd && reg_addr == tc16_pkg::ADDR_STATUS)
        && !(reg_wr && reg_addr == tc16_pkg::ADDR_MASK)
        |=> timer_match_interrupt)
        else $error("interrupt dropped without clear");
    mask_off_a: assert property (reg_wr && reg_addr == tc16_pkg::ADDR_MASK
        && !reg_wdata[0] |=> !timer_match_interrupt)
        else $error("masked interrupt still high");
    unmapped_a: assert property (reg_rd
        && reg_addr > tc16_pkg::ADDR_SYS_CONFIG |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : tc16_asserts

bind timer_counter_16 tc16_asserts #(.CNT_W(CNT_W)) chk_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .count_input_pin(count_input_pin),
    .low_frequency_clock(low_frequency_clock),
    .timer_match_interrupt(timer_match_interrupt));

// file: sim/pulse_source.sv
// Purpose: external pulse source on the count input pin
// Assumes: one burst at a time, started by a one-cycle start
// Notes:   pin rests low between bursts
`timescale 1ns/100ps

module pulse_source
(
    input  wire logic       mclk,
    input  wire logic       start,
    input  wire logic [3:0] pulses,
    input  wire logic [7:0] hi_len,
    output logic            pin,
    output logic            busy
);
    initial
    begin
        pin = 1'b0;
        busy = 1'b0;
    end
    always @(posedge mclk)
        if (start)
        begin
            busy <= 1'b1;
            repeat (pulses)
            begin
                pin <= 1'b1;
                repeat (hi_len) @(posedge mclk);
                pin <= 1'b0;
                repeat (10) @(posedge mclk);
            end
            busy <= 1'b0;
        end
endmodule : pulse_source

// file: sim/tb.sv
// Purpose: self-checking bench for the three-mode timer/counter
// Assumes: low-frequency clock runs at 40 mclk periods
// Notes:   periods measured between interrupt rises
`timescale 1ns/100ps

module tb;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        pin;
    logic        irq;
    logic        busy;
    logic        start = 1'b0;
    logic        fs_clk = 1'b0;
    logic [3:0]  pulses = 4'h0;
    logic [7:0]  hi_len = 8'h0A;
    logic [15:0] v;
    int          error_cnt = 0;
    int          check_count = 0;

    always #5 mclk = ~mclk;
    // slow clock toggles on mclk falls, so its period is exactly 40
    always #200 fs_clk = ~fs_clk;

    timer_counter_16 #(.CNT_W(16)) dut (
        .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .count_input_pin(pin),
        .low_frequency_clock(fs_clk), .timer_match_interrupt(irq));
    pulse_source src (.mclk(mclk), .start(start), .pulses(pulses),
        .hi_len(hi_len), .pin(pin), .busy(busy));

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one idle cycle after every strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk); reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge mclk);
    endtask : rd

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge mclk); #1 n++;
        end
        chk({15'h0000, irq}, 16'h0001);
        @(posedge mclk);
    endtask : wait_irq

    task automatic burst(input logic [3:0] n, input logic [7:0] h);
        while (busy)
            @(posedge mclk);
        pulses <= n; hi_len <= h; start <= 1'b1;
        @(posedge mclk); start <= 1'b0;
        @(posedge mclk);
    endtask : burst

    task automatic t_regs();
        wr(tc16_pkg::ADDR_CONTROL, 16'h001D); rd(tc16_pkg::ADDR_CONTROL);
        chk(v, 16'h001D);
        wr(tc16_pkg::ADDR_CONTROL, 16'h0000);
        wr(tc16_pkg::ADDR_MATCH, 16'hA5C3); rd(tc16_pkg::ADDR_MATCH);
        chk(v, 16'hA5C3);
        wr(tc16_pkg::ADDR_MATCH_HIGH, 16'h005A); rd(tc16_pkg::ADDR_MATCH);
        chk(v, 16'h5AC3);
        wr(tc16_pkg::ADDR_MASK, 16'h0001); rd(tc16_pkg::ADDR_MASK);
        chk(v, 16'h0001);
        rd(4'hF);
        chk(v, 16'h0000);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(tc16_pkg::ADDR_MATCH);
        chk(v, 16'h5AC3);
        rd(tc16_pkg::ADDR_MASK);
        chk(v, 16'h0000);
    endtask : t_regs

    // interval between two interrupt rises, then stop
    task automatic t_period(input logic [15:0] m, input logic [15:0] sys,
                            input logic [15:0] ctl, input int cyc);
        time t0;
        wr(tc16_pkg::ADDR_SYS_CONFIG, sys);
        wr(tc16_pkg::ADDR_MATCH, m);
        wr(tc16_pkg::ADDR_MASK, 16'h0001);
        wr(tc16_pkg::ADDR_CONTROL, ctl);
        wait_irq(9000);
        t0 = $time;
        rd(tc16_pkg::ADDR_STATUS);
        chk(v, 16'h0001);
        wait_irq(9000);
        chk(16'(($time - t0) / 10), 16'(cyc));
        wr(tc16_pkg::ADDR_CONTROL, 16'h0000);
        rd(tc16_pkg::ADDR_COUNT);
        chk(v, 16'h0000);
        rd(tc16_pkg::ADDR_STATUS);
        wr(tc16_pkg::ADDR_SYS_CONFIG, 16'h0000);
    endtask : t_period

    task automatic t_event();
        wr(tc16_pkg::ADDR_MATCH, 16'h0002);
        wr(tc16_pkg::ADDR_CONTROL, 16'h003C);
        burst(4'h2, 8'h0A);
        // first rise is already past when burst returns
        @(posedge pin);
        repeat (8) @(posedge mclk);
        chk({15'h0000, irq}, 16'h0000);
        wait_irq(40);
        rd(tc16_pkg::ADDR_COUNT);
        chk(v, 16'h0000);
        wr(tc16_pkg::ADDR_MASK, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd(tc16_pkg::ADDR_STATUS);
        chk(v, 16'h0001);
        wr(tc16_pkg::ADDR_CONTROL, 16'h0000);
    endtask : t_event

    task automatic t_window();
        wr(tc16_pkg::ADDR_MATCH, 16'h0003);
        wr(tc16_pkg::ADDR_MASK, 16'h0001);
        wr(tc16_pkg::ADDR_CONTROL, 16'h002D);
        repeat (100) @(posedge mclk);
        rd(tc16_pkg::ADDR_COUNT);
        chk(v, 16'h0000);
        burst(4'h1, 8'h40);
        wait_irq(80);
        rd(tc16_pkg::ADDR_STATUS);
        wr(tc16_pkg::ADDR_CONTROL, 16'h0000);
    endtask : t_window

    initial
    begin
        #500000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_period(16'h0004, 16'h0000, 16'h002C, 32);
        t_period(16'h0002, 16'h0000, 16'h0028, 512);
        t_period(16'h0BFF, 16'h0001, 16'h0030, 2048);
        t_period(16'h0002, 16'h0000, 16'h0034, 80);
        t_period(16'h0001, 16'h0002, 16'h0024, 1280);
        t_event();
        t_window();
        test_done();
    end
endmodule : tb
